// ---- rtl/ast_uart.v ----
// Asynchronous serial transceiver with AXI4-Lite registers and two character buffers
`timescale 1ns/1ps
`include "ast_defs.vh"

module ast_fifo #(
    parameter W = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire deep,
    input wire push,
    input wire [W-1:0] push_data,
    input wire pop,
    output wire [W-1:0] pop_data,
    output wire [AW:0] count,
    output wire full,
    output wire empty
);
    localparam [AW:0] FULL_N = DEPTH;
    localparam [AW:0] ONE = 1;
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire do_push;
    wire do_pop;
    // Without buffer enable the queue holds a single character [R13]
    assign full = cnt_q >= (deep ? FULL_N : ONE);
    assign empty = cnt_q == {(AW+1){1'b0}};
    assign count = cnt_q;
    assign pop_data = mem_q[rp_q];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    always @(posedge clk) begin
        if (rst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (do_push) begin
                mem_q[wp_q] <= push_data;
                wp_q <= wp_q + ONE[AW-1:0];
            end
            if (do_pop)
                rp_q <= rp_q + ONE[AW-1:0];
            if (do_push && !do_pop)
                cnt_q <= cnt_q + ONE;
            else if (do_pop && !do_push)
                cnt_q <= cnt_q - ONE;
        end
    end
endmodule

module ast_uart #(
    parameter DEPTH = 16
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire serial_in,
    output wire serial_out,
    output wire irq
);
    localparam [4:0] T_IDLE = 5'h01, T_START = 5'h02, T_DATA = 5'h04, T_PAR = 5'h08,
        T_STOP = 5'h10;
    localparam [5:0] R_IDLE = 6'h01, R_START = 6'h02, R_DATA = 6'h04, R_PAR = 6'h08,
        R_STOP = 6'h10, R_BRK = 6'h20;
    localparam [9:0] RTO_TICKS = `AST_RTO_BITS * `AST_OVS;

    function [4:0] level_of;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: level_of = 5'h02;
                3'h1: level_of = 5'h04;
                3'h2: level_of = 5'h08;
                3'h3: level_of = 5'h0C;
                3'h4: level_of = 5'h0E;
                default: level_of = 5'h08;
            endcase
        end
    endfunction

    function parity_bit;
        input [7:0] d;
        input [7:0] lc;
        begin
            if (lc[`AST_LC_SPS])
                parity_bit = !lc[`AST_LC_EPS];
            else
                parity_bit = lc[`AST_LC_EPS] ? ^d : ~^d;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    reg [15:0] ibrd_q;
    reg [5:0] fbrd_q;
    reg [7:0] lcrh_q;
    reg [9:0] ctl_q;
    reg [5:0] ifls_q;
    reg [10:0] mask_q;
    reg [10:0] ris_q;
    reg [3:0] rsr_q;
    reg [29:0] act_q;
    reg [22:0] acc_q;
    reg aw_have_q, w_have_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg rx_s1_q, rx_s2_q;
    reg [4:0] tx_st_q;
    reg [3:0] tx_tk_q;
    reg [2:0] tx_bit_q;
    reg [7:0] tx_sh_q;
    reg tx_par_q, tx_out_q, tx_stop2_q;
    reg [5:0] rx_st_q;
    reg [3:0] rx_tk_q;
    reg [2:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg rx_pe_q, rx_zero_q, oe_pend_q;
    reg [9:0] rto_q;

    // Active settings: integer divisor, fraction, line control [R6]
    wire [21:0] div_a = act_q[29:8];
    wire [7:0] lc = act_q[7:0];
    wire [2:0] last_bit = {1'b1, lc[`AST_LC_WLEN_LO+1:`AST_LC_WLEN_LO]};
    wire deep = lc[`AST_LC_BUF_EN];
    wire [22:0] acc_n = acc_q + `AST_FRAC_ONE;
    // Fractional accumulator in sixty-fourths of a clock [R3] [R4] [R5]
    wire tick = (div_a != 22'h0) && (acc_n >= {1'b0, div_a});
    wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] wd_m = merge(32'h0, wdata_q, wstrb_q);
    wire [31:0] m_ibrd = merge({16'h0, ibrd_q}, wdata_q, wstrb_q);
    wire [31:0] m_fbrd = merge({26'h0, fbrd_q}, wdata_q, wstrb_q);
    wire [31:0] m_lcrh = merge({24'h0, lcrh_q}, wdata_q, wstrb_q);
    wire [31:0] m_ctl = merge({22'h0, ctl_q}, wdata_q, wstrb_q);
    wire [31:0] m_ifls = merge({26'h0, ifls_q}, wdata_q, wstrb_q);
    wire [31:0] m_mask = merge({21'h0, mask_q}, wdata_q, wstrb_q);
    wire rx_line = ctl_q[`AST_CTL_LOOP] ? tx_out_q : rx_s2_q; // [R21]
    wire tx_run_ok = ctl_q[`AST_CTL_UEN] && ctl_q[`AST_CTL_TX_EN];
    wire rx_run_ok = ctl_q[`AST_CTL_UEN] && ctl_q[`AST_CTL_RX_EN];

    wire [7:0] txf_data;
    wire [4:0] txf_cnt;
    wire txf_full, txf_empty;
    wire [11:0] rxf_data;
    wire [4:0] rxf_cnt;
    wire rxf_full, rxf_empty;
    wire tx_push = do_wr && awaddr_q == `AST_OFF_DR && wstrb_q[0] && !txf_full;
    wire tx_pop = tx_st_q[0] && tx_run_ok && !txf_empty; // [R7]
    wire rx_pop = ar_take && s_axi_araddr == `AST_OFF_DR;
    wire rx_end = rx_st_q[4] && tick && rx_tk_q == `AST_LAST_TICK;
    wire [7:0] rx_al = rx_sh_q >> (3'h7 - last_bit);
    wire rx_fe = !rx_line;
    wire rx_be = rx_zero_q && !rx_line;
    wire rx_push = rx_end && !rxf_full;
    wire rx_over = rx_end && rxf_full; // [R26]
    // Data, then frame, parity, break, overrun flags [R2] [R11] [R25]
    wire [11:0] rx_word = {oe_pend_q, rx_be, rx_pe_q, rx_fe, rx_be ? 8'h00 : rx_al};
    wire busy = !tx_st_q[0] || !txf_empty; // [R8]
    wire [10:0] mis = ris_q & mask_q; // [R18]
    assign irq = |mis; // [R17]
    assign serial_out = tx_out_q;
    assign s_axi_awready = clk_en && !aw_have_q;
    assign s_axi_wready = clk_en && !w_have_q;
    assign s_axi_arready = clk_en && !s_axi_rvalid;

    ast_fifo #(.W(8), .DEPTH(DEPTH), .AW(4)) u_txf (
        .clk(sys_clk), .rst(sys_rst), .ce(clk_en), .deep(deep),
        .push(tx_push), .push_data(wd_m[7:0]), .pop(tx_pop), .pop_data(txf_data),
        .count(txf_cnt), .full(txf_full), .empty(txf_empty)
    ); // [R12] [R13]
    ast_fifo #(.W(12), .DEPTH(DEPTH), .AW(4)) u_rxf (
        .clk(sys_clk), .rst(sys_rst), .ce(clk_en), .deep(deep),
        .push(rx_push), .push_data(rx_word), .pop(rx_pop), .pop_data(rxf_data),
        .count(rxf_cnt), .full(rxf_full), .empty(rxf_empty)
    ); // [R12] [R13]

    // Trigger levels; single-entry mode triggers on any or no character [R15]
    wire rx_lvl = deep ? (rxf_cnt >= level_of(ifls_q[5:3])) : !rxf_empty;
    wire tx_lvl = deep ? (txf_cnt <= level_of(ifls_q[2:0])) : txf_empty;
    reg [10:0] set_v;
    always @* begin
        set_v = 11'h000;
        set_v[`AST_INT_RX] = rx_lvl;
        set_v[`AST_INT_TX] = tx_lvl;
        set_v[`AST_INT_RT] = rto_q == RTO_TICKS - 10'h1 && tick && !rxf_empty;
        set_v[`AST_INT_FE] = rx_push && rx_fe;
        set_v[`AST_INT_PE] = rx_push && rx_pe_q;
        set_v[`AST_INT_BE] = rx_push && rx_be;
        set_v[`AST_INT_OE] = rx_over;
    end

    // Register bus and configuration
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ibrd_q <= 16'h0000;
            fbrd_q <= 6'h00;
            lcrh_q <= 8'h00;
            ctl_q <= `AST_CTL_RESET; // [R24]
            ifls_q <= `AST_IFLS_RESET; // [R16]
            mask_q <= 11'h000;
            ris_q <= 11'h000;
            rsr_q <= 4'h0;
            act_q <= 30'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Clear by write of 1, but a new event in the same cycle wins [R19] [R20]
            ris_q <= (ris_q & ~((do_wr && awaddr_q == `AST_OFF_ICR) ? wd_m[10:0] : 11'h0)
                & ~(rxf_empty ? 11'h040 : 11'h000)) | set_v;
            if (rx_over)
                rsr_q[3] <= 1'b1; // [R14]
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (awaddr_q)
                    `AST_OFF_DR, `AST_OFF_ICR: ;
                    `AST_OFF_RSR: rsr_q <= 4'h0;
                    `AST_OFF_IBRD: ibrd_q <= m_ibrd[15:0];
                    `AST_OFF_FBRD: fbrd_q <= m_fbrd[5:0];
                    `AST_OFF_LCRH: begin
                        lcrh_q <= m_lcrh[7:0];
                        act_q <= {ibrd_q, fbrd_q, m_lcrh[7:0]}; // [R6]
                    end
                    `AST_OFF_CTL: ctl_q <= m_ctl[9:0];
                    `AST_OFF_IFLS: ifls_q <= m_ifls[5:0];
                    `AST_OFF_MASK: mask_q <= m_mask[10:0];
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case ({s_axi_araddr[11:2], 2'h0})
                    `AST_OFF_DR: begin
                        s_axi_rdata <= rxf_empty ? 32'h0 : {20'h0, rxf_data}; // [R12]
                        if (!rxf_empty)
                            rsr_q <= {rsr_q[3] | rxf_data[11], rxf_data[10:8]};
                    end
                    `AST_OFF_RSR: s_axi_rdata <= {28'h0, rsr_q};
                    `AST_OFF_FR: s_axi_rdata <= {24'h0, !txf_empty ? 1'b0 : 1'b1, rxf_full,
                        txf_full, rxf_empty, busy, 3'h0}; // [R14]
                    `AST_OFF_IBRD: s_axi_rdata <= {16'h0, ibrd_q};
                    `AST_OFF_FBRD: s_axi_rdata <= {26'h0, fbrd_q};
                    `AST_OFF_LCRH: s_axi_rdata <= {24'h0, lcrh_q};
                    `AST_OFF_CTL: s_axi_rdata <= {22'h0, ctl_q};
                    `AST_OFF_IFLS: s_axi_rdata <= {26'h0, ifls_q};
                    `AST_OFF_MASK: s_axi_rdata <= {21'h0, mask_q};
                    `AST_OFF_RIS: s_axi_rdata <= {21'h0, ris_q};
                    `AST_OFF_MIS: s_axi_rdata <= {21'h0, mis};
                    `AST_OFF_ICR: s_axi_rdata <= 32'h0;
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
        end
    end

    // Oversample tick generator and receive timeout [R5] [R20]
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_q <= 23'h0;
            rto_q <= 10'h0;
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else if (clk_en) begin
            rx_s1_q <= serial_in;
            rx_s2_q <= rx_s1_q;
            // Held at zero without a divisor, so no tick burst follows setup
            acc_q <= (div_a == 22'h0) ? 23'h0 : tick ? acc_n - {1'b0, div_a} : acc_n;
            if (rxf_empty || rx_push)
                rto_q <= 10'h0;
            else if (tick && rto_q != RTO_TICKS - 10'h1)
                rto_q <= rto_q + 10'h1;
        end
    end

    // Transmit shifter
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_st_q <= T_IDLE;
            tx_tk_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
            tx_out_q <= 1'b1;
            tx_stop2_q <= 1'b0;
        end else if (clk_en) begin
            if (tick && !tx_st_q[0])
                tx_tk_q <= tx_tk_q + 4'h1;
            case (tx_st_q)
                T_IDLE: begin
                    tx_out_q <= 1'b1;
                    if (tx_pop) begin
                        tx_st_q <= T_START;
                        tx_out_q <= 1'b0; // [R1]
                        tx_tk_q <= 4'h0;
                        tx_bit_q <= 3'h0;
                        tx_sh_q <= txf_data;
                        tx_par_q <= parity_bit(txf_data & ~(8'hFF << (last_bit + 4'h1)), lc);
                        tx_stop2_q <= lc[`AST_LC_STP2];
                    end
                end
                T_START: if (tick && tx_tk_q == `AST_LAST_TICK) begin
                    tx_st_q <= T_DATA;
                    tx_out_q <= tx_sh_q[0]; // [R1]
                end
                T_DATA: if (tick && tx_tk_q == `AST_LAST_TICK) begin
                    tx_sh_q <= tx_sh_q >> 1;
                    tx_bit_q <= tx_bit_q + 3'h1;
                    if (tx_bit_q != last_bit) begin
                        tx_out_q <= tx_sh_q[1];
                    end else if (lc[`AST_LC_PEN]) begin
                        tx_st_q <= T_PAR;
                        tx_out_q <= tx_par_q; // [R27]
                    end else begin
                        tx_st_q <= T_STOP;
                        tx_out_q <= 1'b1;
                    end
                end
                T_PAR: if (tick && tx_tk_q == `AST_LAST_TICK) begin
                    tx_st_q <= T_STOP;
                    tx_out_q <= 1'b1;
                end
                T_STOP: if (tick && tx_tk_q == `AST_LAST_TICK) begin
                    // Whole frame ends even if the unit was disabled meanwhile [R23]
                    if (tx_stop2_q)
                        tx_stop2_q <= 1'b0;
                    else
                        tx_st_q <= T_IDLE;
                end
                default: tx_st_q <= T_IDLE;
            endcase
        end
    end

    // Receive sampler
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_st_q <= R_IDLE;
            rx_tk_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_pe_q <= 1'b0;
            rx_zero_q <= 1'b0;
            oe_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (tick && !rx_st_q[0] && !rx_st_q[5])
                rx_tk_q <= rx_tk_q + 4'h1;
            if (rx_over)
                oe_pend_q <= 1'b1;
            else if (rx_push)
                oe_pend_q <= 1'b0;
            case (rx_st_q)
                R_IDLE: if (rx_run_ok && !rx_line) begin
                    rx_st_q <= R_START; // [R9]
                    rx_tk_q <= 4'h0;
                end
                R_START: if (tick && rx_tk_q == `AST_START_TICK) begin
                    rx_tk_q <= 4'h0;
                    rx_bit_q <= 3'h0;
                    rx_pe_q <= 1'b0;
                    rx_zero_q <= 1'b1;
                    rx_st_q <= rx_line ? R_IDLE : R_DATA; // [R9]
                end
                R_DATA: if (tick && rx_tk_q == `AST_LAST_TICK) begin
                    rx_sh_q <= {rx_line, rx_sh_q[7:1]}; // [R10]
                    rx_zero_q <= rx_zero_q && !rx_line;
                    rx_bit_q <= rx_bit_q + 3'h1;
                    if (rx_bit_q == last_bit)
                        rx_st_q <= lc[`AST_LC_PEN] ? R_PAR : R_STOP;
                end
                R_PAR: if (tick && rx_tk_q == `AST_LAST_TICK) begin
                    rx_pe_q <= rx_line != parity_bit(rx_al, lc); // [R10]
                    rx_zero_q <= rx_zero_q && !rx_line;
                    rx_st_q <= R_STOP;
                end
                R_STOP: if (rx_end)
                    rx_st_q <= rx_be ? R_BRK : R_IDLE; // [R11] [R25]
                R_BRK: if (rx_line)
                    rx_st_q <= R_IDLE; // [R25]
                default: rx_st_q <= R_IDLE;
            endcase
        end
    end
endmodule

// ---- rtl/ast_defs.vh ----
// Constants of the serial transceiver
// How it works
// (R1) Frame: start, data LSB first, optional parity, stop bits.
// (R2) Receiver flags overrun, parity, framing, break with each character.
// (R3) Divisor: 16-bit integer plus 6-bit fraction, 22 bits.
// (R4) Divisor is clock over sixteen times bit rate, fraction in 64ths.
// (R5) Tick at sixteen times bit rate; a transmit bit is sixteen ticks.
// (R6) Divisors and line control load together on line-control write.
// (R7) When enabled, send while the transmit buffer holds data.
// (R8) Busy while buffer non-empty or last stop bit unsent.
// (R9) Start bit accepted only if line still low at eighth tick.
// (R10) Data sampled every sixteenth tick, then parity checked.
// (R11) Low stop sample is a framing error; flags stored with data.
// (R12) 16-entry buffers behind one data register; reads 12 bits, writes 8.
// (R13) After reset buffers hold one character until buffer enable.
// (R14) Flag register shows empty and full; status register shows overrun.
// (R15) Trigger levels per buffer: 1/8, 1/4, 1/2, 3/4, 7/8.
// (R16) Both trigger levels reset to half full.
// (R17) Seven interrupt sources ORed into one request.
// (R18) Mask bit 1 passes a source; raw and masked readable.
// (R19) Writing 1 to a clear bit clears that source.
// (R20) Timeout after 32 idle bit periods with data; cleared by empty or clear.
// (R21) Loopback routes transmit output to the receiver.
// (R22) Software disables, writes divisors, line control, then enables.
// (R23) Disabling mid-character lets the character finish.
// (R24) Transmit and receive enable set after reset.
// (R25) Break loads one zero character; next needs line high and start.
// (R26) Character arriving with buffer full is dropped; overrun flagged.
// (R27) 5 to 8 data bits, 1 or 2 stops, four parity modes.
`ifndef AST_DEFS_VH
`define AST_DEFS_VH
`define AST_OFF_DR 12'h000
`define AST_OFF_RSR 12'h004
`define AST_OFF_FR 12'h018
`define AST_OFF_IBRD 12'h024
`define AST_OFF_FBRD 12'h028
`define AST_OFF_LCRH 12'h02C
`define AST_OFF_CTL 12'h030
`define AST_OFF_IFLS 12'h034
`define AST_OFF_MASK 12'h038
`define AST_OFF_RIS 12'h03C
`define AST_OFF_MIS 12'h040
`define AST_OFF_ICR 12'h044
`define AST_LC_PEN 1
`define AST_LC_EPS 2
`define AST_LC_STP2 3
`define AST_LC_BUF_EN 4
`define AST_LC_WLEN_LO 5
`define AST_LC_SPS 7
`define AST_CTL_UEN 0
`define AST_CTL_LOOP 7
`define AST_CTL_TX_EN 8
`define AST_CTL_RX_EN 9
`define AST_CTL_RESET 10'h300
`define AST_IFLS_RESET 6'h12
`define AST_INT_RX 4
`define AST_INT_TX 5
`define AST_INT_RT 6
`define AST_INT_FE 7
`define AST_INT_PE 8
`define AST_INT_BE 9
`define AST_INT_OE 10
`define AST_OVS 16
`define AST_START_TICK 4'h7
`define AST_LAST_TICK 4'hF
`define AST_RTO_BITS 32
`define AST_FRAC_ONE 23'h000040
`endif

// ---- verif/ast_uart_assertions.sv ----
// Port-level checker for the serial transceiver
`timescale 1ns/1ps
module ast_uart_assertions (
    input wire sys_clk,
    input wire sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire serial_out,
    input wire irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_resp: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_resp: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response late");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read answer");
    a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second address taken too early");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_reset_idle: assert property ($fell(sys_rst) |-> serial_out && !irq)
        else $error("line or request not idle after reset");
    // Every serial bit stays stable for at least eight clocks after it changes
    a_bit_width: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
        else $error("serial bit too short");
endmodule
bind ast_uart ast_uart_assertions chk (.*);

// ---- verif/ast_remote.sv ----
// Remote serial device model on the transmit and receive lines
`timescale 1ns/1ps
module ast_remote #(
    parameter BIT = 32
) (
    input wire sys_clk,
    input wire tx_line,
    output reg rx_line
);
    initial rx_line = 1'b1;
    // Start, eight data bits LSB first, stop; a bad stop is cut short
    task send(input [7:0] d, input stop);
        integer i;
        begin
            rx_line <= 1'b0;
            repeat (BIT) @(posedge sys_clk);
            for (i = 0; i < 8; i = i + 1) begin
                rx_line <= d[i];
                repeat (BIT) @(posedge sys_clk);
            end
            rx_line <= stop;
            repeat (stop ? BIT : BIT * 3 / 4) @(posedge sys_clk);
            rx_line <= 1'b1;
            repeat (BIT * 2) @(posedge sys_clk);
        end
    endtask
    // Samples mid-bit; bit 8 of the result is the stop level
    task recv(output [8:0] d);
        integer i;
        begin
            @(negedge tx_line);
            repeat (BIT / 2) @(posedge sys_clk);
            for (i = 0; i < 9; i = i + 1) begin
                repeat (BIT) @(posedge sys_clk);
                d[i] = tx_line;
            end
        end
    endtask
endmodule

// ---- verif/test_async_serial_transceiver.sv ----
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
`include "ast_defs.vh"
module test_async_serial_transceiver;
    localparam BIT = 16 * 2;
    reg sys_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [11:0] awaddr = 12'h000;
    reg [11:0] araddr = 12'h000;
    reg [31:0] wdata = 32'h00000000;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg arvalid = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, serial_out, irq, rx_line;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer fails = 0;
    integer total_checks = 0;
    integer i;
    reg [31:0] d;
    reg [1:0] r2;
    reg [8:0] got;
    always #4 sys_clk = ~sys_clk;
    ast_uart dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .serial_in(rx_line), .serial_out(serial_out), .irq(irq));
    ast_remote #(.BIT(BIT)) rem (.sys_clk(sys_clk), .tx_line(serial_out), .rx_line(rx_line));
    task chk(input [31:0] g, input [31:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] v);
        reg ta, tw, b;
        begin
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            b = 1'b0;
            while (!b) begin
                @(negedge sys_clk);
                ta = awready && awvalid;
                tw = wready && wvalid;
                b = bvalid;
                @(posedge sys_clk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
            end
        end
    endtask
    task rd(input [11:0] a, output [31:0] v, output [1:0] r);
        reg t, ta;
        begin
            araddr <= a;
            arvalid <= 1'b1;
            t = 1'b0;
            while (!t) begin
                @(negedge sys_clk);
                ta = arready && arvalid;
                t = rvalid;
                v = rdata;
                r = rresp;
                @(posedge sys_clk);
                if (ta) arvalid <= 1'b0;
            end
        end
    endtask
    task rc(input [11:0] a, input [31:0] m, input [31:0] e);
        begin
            rd(a, d, r2);
            chk(d & m, e);
        end
    endtask
    task cfg(input [31:0] lc, input [31:0] ctl);
        begin
            wr(`AST_OFF_CTL, 32'h0);
            wr(`AST_OFF_IBRD, 32'h2);
            wr(`AST_OFF_FBRD, 32'h0);
            wr(`AST_OFF_LCRH, lc);
            wr(`AST_OFF_CTL, ctl);
        end
    endtask
    task t_reset;
        begin
            rc(`AST_OFF_CTL, 32'h3FF, 32'h300);
            rc(`AST_OFF_IFLS, 32'h3F, 32'h12);
            rc(`AST_OFF_FR, 32'hF8, 32'h90);
            rd(12'h048, d, r2);
            chk({30'h0, r2}, 32'h2);
        end
    endtask
    task t_tx;
        begin
            cfg(32'h60, 32'h301);
            fork
                rem.recv(got);
                begin
                    wr(`AST_OFF_DR, 32'hA5);
                    rc(`AST_OFF_FR, 32'h8, 32'h8);
                end
            join
            chk({23'h0, got}, 32'h1A5);
            repeat (BIT) @(posedge sys_clk);
            rc(`AST_OFF_FR, 32'h88, 32'h80);
        end
    endtask
    task t_rx;
        begin
            rem.send(8'h3C, 1'b1);
            rc(`AST_OFF_DR, 32'hFFF, 32'h03C);
            rem.send(8'hC3, 1'b0);
            rc(`AST_OFF_DR, 32'hFFF, 32'h1C3);
            rem.send(8'h55, 1'b1);
            repeat (1100) @(posedge sys_clk);
            rc(`AST_OFF_RIS, 32'h40, 32'h40);
            rc(`AST_OFF_DR, 32'hFFF, 32'h055);
            rc(`AST_OFF_RIS, 32'h40, 32'h0);
        end
    endtask
    task t_overrun;
        begin
            rem.send(8'h11, 1'b1);
            rem.send(8'h22, 1'b1);
            rc(`AST_OFF_RSR, 32'h8, 32'h8);
            rc(`AST_OFF_RIS, 32'h400, 32'h400);
            rc(`AST_OFF_DR, 32'hFFF, 32'h011);
            rem.send(8'h33, 1'b1);
            rc(`AST_OFF_DR, 32'hFFF, 32'h833);
            wr(`AST_OFF_MASK, 32'h400);
            chk({31'h0, irq}, 32'h1);
            rc(`AST_OFF_MIS, 32'h7F0, 32'h400);
            wr(`AST_OFF_ICR, 32'h400);
            chk({31'h0, irq}, 32'h0);
            rc(`AST_OFF_RIS, 32'h400, 32'h0);
            wr(`AST_OFF_RSR, 32'h0);
        end
    endtask
    task t_fifo;
        begin
            cfg(32'h70, 32'h301);
            wr(`AST_OFF_ICR, 32'h7F0);
            for (i = 0; i < 16; i = i + 1) begin
                rem.send(i[7:0] + 8'h40, 1'b1);
                if (i == 6) rc(`AST_OFF_RIS, 32'h10, 32'h0);
                if (i == 7) rc(`AST_OFF_RIS, 32'h10, 32'h10);
            end
            rc(`AST_OFF_FR, 32'h50, 32'h40);
            for (i = 0; i < 16; i = i + 1)
                rc(`AST_OFF_DR, 32'hFFF, i + 32'h40);
            rc(`AST_OFF_FR, 32'h50, 32'h10);
        end
    endtask
    task t_loop;
        begin
            cfg(32'h70, 32'h381);
            wr(`AST_OFF_DR, 32'h5A);
            repeat (BIT * 12) @(posedge sys_clk);
            rc(`AST_OFF_DR, 32'hFFF, 32'h05A);
        end
    endtask
    task complete_run;
        begin
            if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails = fails + 1;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_tx;
        t_rx;
        t_overrun;
        t_fifo;
        t_loop;
        complete_run;
    end
endmodule
